// [rtl/host_register_bus_port.sv]
// Purpose: Asynchronous 8-bit host register port with master reset.
// Assumes: Host pins are synchronised to clock before use.
// Notes: Writes commit on the synchronised rising edge of the write strobe.
// Behaviour
// - Write strobe rising with chip select low stores data into addressed register.
// - Address latch enable high passes address; low holds last captured address.
// - The 11-bit address is decoded to select the register accessed.
// - Low device reset clears the device and sets test mode again, without waiting for a clock.
// - Line inputs sample on rising or falling edge chosen by software.
// - Data bus driven with register contents while read strobe and select low.
// - Interrupt output held low while any unmasked source active.
`timescale 1ns/1ps
`default_nettype none
module host_register_bus_port
  import host_port_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and resets.
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic device_reset_n,
  // Host bus.
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic addrLatchEn,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  // Interrupt pin, open drain.
  input wire logic [SRC_W-1:0] irqSources,
  output logic irqOut,
  output logic irqOe,
  // Line-side sampling.
  input wire logic lineClk,
  input wire logic lineData,
  output logic lineSample,
  output logic testModeActive
);
  localparam int IDX_W = $clog2(DEPTH);
  logic rstN;
  logic [1:0] rstRelease_r;
  logic [3:0] ctlSync;
  logic [ADDR_W-1:0] addrSync;
  logic [DATA_W-1:0] dataSync;
  logic [SRC_W-1:0] srcSync;
  logic [1:0] lineSync;
  logic [ADDR_W-1:0] addrHeld_r;
  logic wrN_r, lineClk_r;
  logic [DATA_W-1:0] regs_r [DEPTH];
  logic [DATA_W-1:0] irqMask_r;
  access_state_t state_r, state_nxt;

  // The low address bits pick the storage word for reads, writes and the edge select.
  function automatic logic [IDX_W-1:0] wordIndex(input logic [ADDR_W-1:0] addr);
    return addr[IDX_W-1:0];
  endfunction : wordIndex

  // Reset takes hold at once from the pin but leaves only on a clock edge,
  // so no flop sees its reset released close to a sampling instant.
  always_ff @(posedge clock or negedge device_reset_n) begin
    if (!device_reset_n) begin
      rstRelease_r <= '0;
    end else begin
      rstRelease_r <= {rstRelease_r[0], ~sys_rst};
    end
  end
  assign rstN = rstRelease_r[1];

  // Select resets as seen low, so only a real high level on the pin ends test mode.
  sync_two_ff #(.WIDTH(4), .INIT(4'h7)) uCtl (.clock(clock), .arstN(rstN),
    .din({chip_select_n, read_strobe_n, write_strobe_n, addrLatchEn}), .dout(ctlSync));
  sync_two_ff #(.WIDTH(ADDR_W)) uAddr (.clock(clock), .arstN(rstN),
    .din(addrIn), .dout(addrSync));
  sync_two_ff #(.WIDTH(DATA_W)) uData (.clock(clock), .arstN(rstN),
    .din(dataIn), .dout(dataSync));
  sync_two_ff #(.WIDTH(SRC_W)) uSrc (.clock(clock), .arstN(rstN),
    .din(irqSources), .dout(srcSync));
  sync_two_ff #(.WIDTH(2)) uLine (.clock(clock), .arstN(rstN),
    .din({lineClk, lineData}), .dout(lineSync));

  wire csN = ctlSync[3];
  wire rdN = ctlSync[2];
  wire wrN = ctlSync[1];
  wire ale = ctlSync[0];
  // With latch enable low the held address is used, so the bus may reuse its lines.
  wire [ADDR_W-1:0] addrEff = ale ? addrSync : addrHeld_r;
  // Only a strobe that was held low in the write state may commit when it rises.
  wire wrCommit = (state_r == ST_WRITE) & wrN & ~wrN_r & ~csN;
  wire rdActive = ~rdN & ~csN;
  wire hitEdge = (addrEff == ADDR_EDGE_SEL);
  wire hitMask = (addrEff == ADDR_IRQ_MASK);
  wire hitStat = (addrEff == ADDR_IRQ_STAT);
  wire inArray = (addrEff < ADDR_W'(DEPTH));
  wire [IDX_W-1:0] wordIdx = wordIndex(addrEff);
  wire [DATA_W-1:0] arrWord = regs_r[wordIdx];
  // Addresses beyond the storage read as zero.
  wire [DATA_W-1:0] rdWord = hitMask ? irqMask_r :
    hitStat ? (srcSync & irqMask_r) : inArray ? arrWord : DATA_RESET;
  // Bit 0 of word 0 picks the active edge of the line clock.
  wire riseEdgeSel = regs_r[wordIndex(ADDR_EDGE_SEL)][EDGE_BIT];
  wire lineEdge = riseEdgeSel ? (lineSync[1] & ~lineClk_r)
                              : (~lineSync[1] & lineClk_r);

  // Access tracker; a read has priority when both strobes are low.
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = rdActive ? ST_READ : (~wrN & ~csN) ? ST_WRITE : ST_IDLE;
      ST_READ: state_nxt = rdActive ? ST_READ : ST_IDLE;
      ST_WRITE: state_nxt = wrN ? ST_IDLE : ST_WRITE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      addrHeld_r <= ADDR_RESET;
      wrN_r <= 1'b1;
      lineClk_r <= 1'b0;
      state_r <= ST_IDLE;
      irqMask_r <= DATA_RESET;
      dataOut <= DATA_RESET;
      dataOe <= 1'b0;
      irqOut <= 1'b0;
      irqOe <= 1'b0;
      lineSample <= 1'b0;
      testModeActive <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        regs_r[i] <= DATA_RESET;
      end
    end else begin
      if (ale) begin
        addrHeld_r <= addrSync;
      end
      wrN_r <= wrN;
      lineClk_r <= lineSync[1];
      state_r <= state_nxt;
      if (wrCommit && hitMask) begin
        irqMask_r <= dataSync;
      end else if (wrCommit && inArray && !hitStat) begin
        regs_r[wordIdx] <= dataSync;
      end
      dataOut <= rdWord;
      dataOe <= rdActive;
      irqOe <= |(srcSync & irqMask_r);
      if (lineEdge) begin
        lineSample <= lineSync[0];
      end
      // Any high level of select ends the power-up test mode.
      if (csN) begin
        testModeActive <= 1'b0;
      end
    end
  end

  // Port timing checks.
  a_read_drive: assert property (@(posedge clock) disable iff (!rstN)
    (~rdN & ~csN) |=> dataOe) else $error("data bus not driven during read");
  a_bus_release: assert property (@(posedge clock) disable iff (!rstN)
    !(~rdN & ~csN) |=> !dataOe) else $error("data bus driven outside read");
  a_irq_low: assert property (@(posedge clock) disable iff (!rstN)
    (|(srcSync & irqMask_r)) |=> irqOe && !irqOut) else $error("interrupt not asserted");
  a_irq_release: assert property (@(posedge clock) disable iff (!rstN)
    !(|(srcSync & irqMask_r)) |=> !irqOe) else $error("interrupt not released");
  a_mask_write: assert property (@(posedge clock) disable iff (!rstN)
    (wrCommit && hitMask) |=> irqMask_r == $past(dataSync)) else $error("write lost");
  a_addr_hold: assert property (@(posedge clock) disable iff (!rstN)
    (!ale && !$past(ale)) |-> $stable(addrHeld_r)) else $error("address moved");
  a_no_write: assert property (@(posedge clock) disable iff (!rstN)
    (!wrCommit && !$past(wrCommit)) |-> $stable(irqMask_r)) else $error("spurious write");
  a_edge_sample: assert property (@(posedge clock) disable iff (!rstN)
    lineEdge |=> lineSample == $past(lineSync[0])) else $error("line sample missed");
  a_async_reset: assert property (@(posedge clock)
    !device_reset_n |-> !dataOe && !irqOe) else $error("reset not asynchronous");

  // A write is the strobe held low in the write state, then seen high with select low.
  sequence wrLowSeq;
    (state_r == ST_WRITE) && !wrN && !csN;
  endsequence
  sequence wrRiseSeq;
    wrN && !csN;
  endsequence

  a_write_enter: assert property (@(posedge clock) disable iff (!rstN)
    (state_r == ST_IDLE && rdN && !wrN && !csN) |=> state_r == ST_WRITE)
    else $error("write state not entered");
  a_write_commit: assert property (@(posedge clock) disable iff (!rstN)
    wrLowSeq ##1 wrRiseSeq |-> wrCommit)
    else $error("write strobe rise not committed");
  a_array_write: assert property (@(posedge clock) disable iff (!rstN)
    (wrCommit && inArray && !hitMask && !hitStat) |=> regs_r[$past(wordIdx)] == $past(dataSync))
    else $error("register write lost");
  a_range_write: assert property (@(posedge clock) disable iff (!rstN)
    (wrCommit && !inArray) |=> $stable(irqMask_r))
    else $error("write beyond storage took effect");
  a_stat_read: assert property (@(posedge clock) disable iff (!rstN)
    (rdActive && hitStat) |=> dataOut == ($past(srcSync) & $past(irqMask_r)))
    else $error("status read wrong");
  a_mask_read: assert property (@(posedge clock) disable iff (!rstN)
    (rdActive && hitMask) |=> dataOut == $past(irqMask_r))
    else $error("mask read wrong");
  a_range_read: assert property (@(posedge clock) disable iff (!rstN)
    (rdActive && !inArray) |=> dataOut == DATA_RESET)
    else $error("read beyond storage not zero");

  a_addr_follow: assert property (@(posedge clock) disable iff (!rstN)
    ale |=> addrHeld_r == $past(addrSync))
    else $error("address not captured while transparent");
  a_test_clear: assert property (@(posedge clock) disable iff (!rstN)
    csN |=> !testModeActive)
    else $error("test mode not cleared");
  a_line_hold: assert property (@(posedge clock) disable iff (!rstN)
    !lineEdge |=> $stable(lineSample))
    else $error("line sample moved without an edge");
endmodule : host_register_bus_port
`default_nettype wire

// [inc/host_port_pkg.sv]
// Purpose: Shared constants for the host register port.
// Assumes: One 100 MHz clock; host pins arrive asynchronously.
// Notes: Register contents beyond the port are kept in a small local array.
package host_port_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int SRC_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 11'h001;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 11'h002;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam int EDGE_BIT = 0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } access_state_t;
endpackage : host_port_pkg

// [rtl/sync_two_ff.sv]
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs are quasi-static relative to clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic arstN,
  // Data.
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1_r;
  always_ff @(posedge clock or negedge arstN) begin
    if (!arstN) begin
      stage1_r <= INIT;
      dout <= INIT;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule : sync_two_ff
`default_nettype wire

// [test/host_cpu_model.sv]
// Purpose: Host processor model that drives the register port bus.
// Assumes: Strobes are held at least three clocks in each level.
// Notes: Write data is inverted after each cycle so stale data cannot pass.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
  import host_port_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Host bus.
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic addrLatchEn,
  output logic [ADDR_W-1:0] addrIn,
  output logic [DATA_W-1:0] dataIn,
  input wire logic [DATA_W-1:0] dataOut
);
  initial begin
    chip_select_n = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addrLatchEn = 1'b1;
    addrIn = 11'h000;
    dataIn = 8'h00;
  end
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic ale, output logic [DATA_W-1:0] q);
    @(posedge clock);
    addrLatchEn <= ale;
    addrIn <= a;
    dataIn <= d;
    chip_select_n <= 1'b0;
    if (wr) write_strobe_n <= 1'b0;
    else read_strobe_n <= 1'b0;
    repeat (5) @(posedge clock);
    q = dataOut;
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (4) @(posedge clock);
    chip_select_n <= 1'b1;
    dataIn <= ~d;
    repeat (4) @(posedge clock);
  endtask : access
endmodule : host_cpu_model
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for the host register port.
// Assumes: Host model keeps the strobe timing of the port.
// Notes: Line sampling is judged in both edge modes.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import host_port_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic device_reset_n = 1'b1;
  logic [SRC_W-1:0] irqSources = 8'h00;
  logic lineClk = 1'b0;
  logic lineData = 1'b0;
  logic csN, rdN, wrN, ale, dataOe, irqOut, irqOe, lineSample, testModeActive;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] din, dout, q;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  host_register_bus_port #(.DEPTH(16)) u_host_register_bus_port (.clock(clock), .sys_rst(sys_rst),
    .device_reset_n(device_reset_n), .chip_select_n(csN), .read_strobe_n(rdN),
    .write_strobe_n(wrN), .addrLatchEn(ale), .addrIn(addr), .dataIn(din), .dataOut(dout),
    .dataOe(dataOe), .irqSources(irqSources), .irqOut(irqOut), .irqOe(irqOe),
    .lineClk(lineClk), .lineData(lineData), .lineSample(lineSample),
    .testModeActive(testModeActive));
  host_cpu_model u_host_cpu_model (.clock(clock), .chip_select_n(csN), .read_strobe_n(rdN),
    .write_strobe_n(wrN), .addrLatchEn(ale), .addrIn(addr), .dataIn(din), .dataOut(dout));
  always #5 clock = ~clock;
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rw(input logic wr, input logic [10:0] a, input logic [7:0] d, input logic l);
    u_host_cpu_model.access(wr, a, d, l, q);
  endtask : rw
  task automatic test_storage();
    check("testMode", {7'h00, testModeActive}, 8'h01);
    rw(1'b0, 11'h003, 8'h00, 1'b1);
    check("testMode", {7'h00, testModeActive}, 8'h00);
    rw(1'b1, 11'h003, 8'h3c, 1'b1);
    rw(1'b1, 11'h00f, 8'hc3, 1'b1);
    rw(1'b0, 11'h003, 8'h00, 1'b1);
    check("reg3", q, 8'h3c);
    rw(1'b0, 11'h00f, 8'h00, 1'b1);
    check("reg15", q, 8'hc3);
    check("dataOe", {7'h00, dataOe}, 8'h00);
    rw(1'b1, 11'h002, 8'hff, 1'b1);
    rw(1'b1, 11'h010, 8'hff, 1'b1);
    rw(1'b0, 11'h010, 8'h00, 1'b1);
    check("reg16", q, 8'h00);
  endtask : test_storage
  task automatic test_latch();
    rw(1'b1, 11'h004, 8'ha5, 1'b1);
    rw(1'b0, 11'h004, 8'h00, 1'b0);
    rw(1'b0, 11'h005, 8'h00, 1'b0);
    check("held", q, 8'ha5);
  endtask : test_latch
  task automatic test_line();
    lineData <= 1'b1;
    repeat (4) @(posedge clock);
    lineClk <= 1'b1;
    repeat (5) @(posedge clock);
    check("lineRiseIgnored", {7'h00, lineSample}, 8'h00);
    lineClk <= 1'b0;
    repeat (5) @(posedge clock);
    check("lineFall", {7'h00, lineSample}, 8'h01);
    rw(1'b1, ADDR_EDGE_SEL, 8'h01, 1'b1);
    lineData <= 1'b0;
    repeat (4) @(posedge clock);
    lineClk <= 1'b1;
    repeat (5) @(posedge clock);
    check("lineRise", {7'h00, lineSample}, 8'h00);
    lineData <= 1'b1;
    repeat (4) @(posedge clock);
    lineClk <= 1'b0;
    repeat (5) @(posedge clock);
    check("lineFallIgnored", {7'h00, lineSample}, 8'h00);
  endtask : test_line
  task automatic test_irq_reset();
    rw(1'b1, 11'h001, 8'h01, 1'b1);
    irqSources <= 8'h02;
    repeat (6) @(posedge clock);
    check("irqMasked", {7'h00, irqOe}, 8'h00);
    irqSources <= 8'h03;
    rw(1'b0, 11'h002, 8'h00, 1'b1);
    check("status", q, 8'h01);
    check("irqOe", {7'h00, irqOe}, 8'h01);
    check("irqPin", {7'h00, irqOut}, 8'h00);
    irqSources <= 8'h02;
    repeat (6) @(posedge clock);
    check("irqAck", {7'h00, irqOe}, 8'h00);
    irqSources <= 8'h01;
    rw(1'b1, 11'h006, 8'h5a, 1'b1);
    rw(1'b0, 11'h006, 8'h00, 1'b1);
    check("reg6", q, 8'h5a);
    check("irqAgain", {7'h00, irqOe}, 8'h01);
    device_reset_n <= 1'b0;
    irqSources <= 8'h00;
    #2;
    check("irqAsync", {7'h00, irqOe}, 8'h00);
    check("testModeRst", {7'h00, testModeActive}, 8'h01);
    repeat (RESET_MIN_CYC) @(posedge clock);
    device_reset_n <= 1'b1;
    @(posedge clock);
    rw(1'b0, 11'h006, 8'h00, 1'b1);
    check("reg6Reset", q, 8'h00);
  endtask : test_irq_reset
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    test_storage();
    test_latch();
    test_line();
    test_irq_reset();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
